// [src/acx_pkg.sv]
package acx_pkg;

	// Operation decoded from the instruction word, one-hot
	typedef enum logic [3:0] {
		OP_NONE = 4'h1,
		OP_ADDC = 4'h2,
		OP_ANDF = 4'h4,
		OP_ANDL = 4'h8
	} acx_op_type;

	// Quarter phases of one instruction cycle, one-hot
	typedef enum logic [3:0] {
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} acx_phase_type;

	// Opcode patterns
	localparam logic [5:0] ADDC_PATTERN  = 6'h08;  // 0010 00da
	localparam logic [5:0] ANDF_PATTERN  = 6'h05;  // 0001 01da
	localparam logic [7:0] ANDL_PATTERN  = 8'h0b;  // 0000 1011

	// Instruction field positions
	localparam int OPC6_HI    = 15;
	localparam int OPC6_LO    = 10;
	localparam int OPC8_LO    = 8;
	localparam int DEST_BIT   = 9;
	localparam int BANK_BIT   = 8;

	// Addressing
	localparam logic [7:0] INDEXED_LIMIT   = 8'h5f;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_SFR_BANK = 4'hf;

	// Data path widths and flag positions
	localparam int SIGN_BIT  = 7;
	localparam int FLAG_C    = 0;
	localparam int FLAG_HALF = 1;
	localparam int FLAG_Z    = 2;
	localparam int FLAG_SOVF = 3;
	localparam int FLAG_N    = 4;
	localparam logic [4:0] FLAGS_RESET = 5'h00;
	localparam logic [7:0] WREG_RESET  = 8'h00;
	localparam logic [11:0] ADDR_RESET = 12'h000;

	// Decode of the three supported instructions
	function automatic acx_op_type decode_op(input logic [15:0] word);
		if (word[OPC6_HI:OPC6_LO] == ADDC_PATTERN) begin
			decode_op = OP_ADDC;
		end else if (word[OPC6_HI:OPC6_LO] == ANDF_PATTERN) begin
			decode_op = OP_ANDF;
		end else if (word[OPC6_HI:OPC8_LO] == ANDL_PATTERN) begin
			decode_op = OP_ANDL;
		end else begin
			decode_op = OP_NONE;
		end
	endfunction

endpackage

// [src/acx_alu_if.sv]
`timescale 1ns/1ps
interface acx_alu_if;
	acx_pkg::acx_op_type op;
	logic [7:0]          a;
	logic [7:0]          b;
	logic                cin;
	logic [7:0]          result;
	logic [4:0]          flags;
	logic [4:0]          flag_mask;

	modport alu  (input op, a, b, cin, output result, flags, flag_mask);
	modport core (output op, a, b, cin, input result, flags, flag_mask);
endinterface

// [src/acx_alu.sv]
`timescale 1ns/1ps
module acx_alu (
	// Operands and results
	acx_alu_if.alu bus
);

	////////////////////////////////////////////////////////////////////////
	logic [8:0] sum9;
	logic [4:0] half5;

	// Result and flags; mask marks which flags the op may change
	always_comb begin
		sum9          = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.cin};
		half5         = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
		bus.result    = 8'h00;
		bus.flags     = acx_pkg::FLAGS_RESET;
		bus.flag_mask = 5'h00;
		case (bus.op)
			acx_pkg::OP_ADDC: begin
				bus.result                     = sum9[7:0];
				bus.flags[acx_pkg::FLAG_C]     = sum9[8];
				bus.flags[acx_pkg::FLAG_HALF]  = half5[4];
				// Same-sign operands giving other-sign sum
				bus.flags[acx_pkg::FLAG_SOVF]  =
					(bus.a[acx_pkg::SIGN_BIT] == bus.b[acx_pkg::SIGN_BIT]) &&
					(sum9[acx_pkg::SIGN_BIT] != bus.a[acx_pkg::SIGN_BIT]);
				bus.flag_mask                  = 5'h1f;
			end
			acx_pkg::OP_ANDF, acx_pkg::OP_ANDL: begin
				bus.result                     = bus.a & bus.b;
				bus.flag_mask[acx_pkg::FLAG_Z] = 1'b1;
				bus.flag_mask[acx_pkg::FLAG_N] = 1'b1;
			end
			default: begin
				bus.result = 8'h00;
			end
		endcase
		bus.flags[acx_pkg::FLAG_Z] = (bus.result == 8'h00);
		bus.flags[acx_pkg::FLAG_N] = bus.result[acx_pkg::SIGN_BIT];
	end

endmodule // acx_alu

// [src/acx_exec.sv]
`timescale 1ns/1ps
// Behaviour
// - Add-with-carry sums working register, carry and file byte and updates all five flags.
// - For file ops a destination bit of 0 writes the working register, 1 writes the file byte.
// - Bank bit 0 selects the access bank, bank bit 1 combines the address with the bank select.
// - Bank bit 0 with extended set enabled and address at most 5Fh uses indexed offset.
// - Literal AND puts working register AND literal into the working register, N and Z only.
// - Register AND combines working register with the file byte, routed by destination, N, Z.
// - Each instruction is one word and one cycle of decode, read, process and write quarters.
module acx_exec (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Instruction from fetch
	input  wire logic [15:0] instr_word,
	input  wire logic        instr_valid,
	// Addressing configuration
	input  wire logic [3:0]  bank_select_register,
	input  wire logic        ext_set_enable,
	input  wire logic [11:0] index_base,
	// Data memory
	output logic      [11:0] mem_addr,
	output logic             mem_rd_en,
	input  wire logic [7:0]  mem_rd_data,
	output logic             mem_wr_en,
	output logic      [7:0]  mem_wr_data,
	// Working register and status
	output logic      [7:0]  wreg,
	output logic             flag_n,
	output logic             signed_overflow_flag,
	output logic             flag_z,
	output logic             half_carry_flag,
	output logic             flag_c,
	// Progress
	output logic      [3:0]  quarter,
	output logic             instr_done
);

	////////////////////////////////////////////////////////////////////////
	acx_pkg::acx_phase_type phase_reg, phase_next;
	acx_pkg::acx_op_type    op_reg, op_next;
	logic [7:0]             lit_reg, lit_next;
	logic                   dest_reg, dest_next;
	logic [11:0]            addr_reg, addr_next;
	logic                   rd_en_reg, rd_en_next;
	logic                   wr_en_reg, wr_en_next;
	logic [7:0]             wr_data_reg, wr_data_next;
	logic [7:0]             wreg_reg, wreg_next;
	logic [4:0]             flags_reg, flags_next;
	logic                   done_reg, done_next;
	logic [7:0]             f_field;
	logic                   file_op;

	acx_alu_if alu_bus ();

	acx_alu u_alu (
		.bus (alu_bus.alu)
	);

	////////////////////////////////////////////////////////////////////////
	// Operands: literal op takes the latched literal, file ops the read byte
	assign alu_bus.op  = op_reg;
	assign alu_bus.a   = wreg_reg;
	assign alu_bus.b   = (op_reg == acx_pkg::OP_ANDL) ? lit_reg : mem_rd_data;
	assign alu_bus.cin = flags_reg[acx_pkg::FLAG_C];

	assign f_field = instr_word[7:0];
	assign file_op = (acx_pkg::decode_op(instr_word) == acx_pkg::OP_ADDC) ||
	                 (acx_pkg::decode_op(instr_word) == acx_pkg::OP_ANDF);

	////////////////////////////////////////////////////////////////////////
	// Quarter sequencer and datapath next state
	always_comb begin
		phase_next   = phase_reg;
		op_next      = op_reg;
		lit_next     = lit_reg;
		dest_next    = dest_reg;
		addr_next    = addr_reg;
		rd_en_next   = 1'b0;
		wr_en_next   = 1'b0;
		wr_data_next = wr_data_reg;
		wreg_next    = wreg_reg;
		flags_next   = flags_reg;
		done_next    = 1'b0;
		case (phase_reg)
			acx_pkg::PH_Q1: begin
				// Decode; an absent word becomes a one-cycle no-op
				phase_next = acx_pkg::PH_Q2;
				op_next    = instr_valid ? acx_pkg::decode_op(instr_word) : acx_pkg::OP_NONE;
				lit_next   = f_field;
				dest_next  = instr_word[acx_pkg::DEST_BIT];
				rd_en_next = instr_valid && file_op;
				if (instr_word[acx_pkg::BANK_BIT]) begin
					addr_next = {bank_select_register, f_field};
				end else if (ext_set_enable && (f_field <= acx_pkg::INDEXED_LIMIT)) begin
					addr_next = index_base + {4'h0, f_field};
				end else if (f_field <= acx_pkg::INDEXED_LIMIT) begin
					addr_next = {acx_pkg::ACCESS_LOW_BANK, f_field};
				end else begin
					addr_next = {acx_pkg::ACCESS_SFR_BANK, f_field};
				end
			end
			acx_pkg::PH_Q2: begin
				phase_next = acx_pkg::PH_Q3;
			end
			acx_pkg::PH_Q3: begin
				// Read data is valid now; results become visible in Q4
				phase_next = acx_pkg::PH_Q4;
				if (op_reg != acx_pkg::OP_NONE) begin
					flags_next = (flags_reg & ~alu_bus.flag_mask) |
					             (alu_bus.flags & alu_bus.flag_mask);
					if (op_reg != acx_pkg::OP_ANDL && dest_reg) begin
						wr_en_next   = 1'b1;
						wr_data_next = alu_bus.result;
					end else begin
						wreg_next = alu_bus.result;
					end
				end
			end
			acx_pkg::PH_Q4: begin
				phase_next = acx_pkg::PH_Q1;
				done_next  = 1'b1;
			end
			default: begin
				phase_next = acx_pkg::PH_Q1;
			end
		endcase
	end

	// Register stage
	always_ff @(posedge core_clk) begin
		if (rst) begin
			phase_reg   <= acx_pkg::PH_Q1;
			op_reg      <= acx_pkg::OP_NONE;
			lit_reg     <= 8'h00;
			dest_reg    <= 1'b0;
			addr_reg    <= acx_pkg::ADDR_RESET;
			rd_en_reg   <= 1'b0;
			wr_en_reg   <= 1'b0;
			wr_data_reg <= 8'h00;
			wreg_reg    <= acx_pkg::WREG_RESET;
			flags_reg   <= acx_pkg::FLAGS_RESET;
			done_reg    <= 1'b0;
		end else begin
			phase_reg   <= phase_next;
			op_reg      <= op_next;
			lit_reg     <= lit_next;
			dest_reg    <= dest_next;
			addr_reg    <= addr_next;
			rd_en_reg   <= rd_en_next;
			wr_en_reg   <= wr_en_next;
			wr_data_reg <= wr_data_next;
			wreg_reg    <= wreg_next;
			flags_reg   <= flags_next;
			done_reg    <= done_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flops
	assign mem_addr             = addr_reg;
	assign mem_rd_en            = rd_en_reg;
	assign mem_wr_en            = wr_en_reg;
	assign mem_wr_data          = wr_data_reg;
	assign wreg                 = wreg_reg;
	assign flag_n               = flags_reg[acx_pkg::FLAG_N];
	assign signed_overflow_flag = flags_reg[acx_pkg::FLAG_SOVF];
	assign flag_z               = flags_reg[acx_pkg::FLAG_Z];
	assign half_carry_flag      = flags_reg[acx_pkg::FLAG_HALF];
	assign flag_c               = flags_reg[acx_pkg::FLAG_C];
	assign quarter              = phase_reg;
	assign instr_done           = done_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	chk_quarter_order: assert property (@(posedge core_clk) disable iff (rst)
		phase_reg == acx_pkg::PH_Q1 |=> phase_reg == acx_pkg::PH_Q2 ##1
		phase_reg == acx_pkg::PH_Q3 ##1 phase_reg == acx_pkg::PH_Q4 ##1 instr_done)
		else $error("quarter sequence broken");

	chk_add_sum: assert property (@(posedge core_clk) disable iff (rst)
		(phase_reg == acx_pkg::PH_Q3 && op_reg == acx_pkg::OP_ADDC && !dest_reg) |=>
		wreg_reg == 8'($past(wreg_reg) + $past(mem_rd_data) + {7'h00, $past(flag_c)}))
		else $error("add with carry result wrong");

	chk_dest_file: assert property (@(posedge core_clk) disable iff (rst)
		(phase_reg == acx_pkg::PH_Q3 && op_reg != acx_pkg::OP_NONE) |=>
		(mem_wr_en == ($past(dest_reg) && $past(op_reg) != acx_pkg::OP_ANDL)) &&
		(mem_wr_en ? $stable(wreg_reg) : 1'b1))
		else $error("destination routing wrong");

	chk_bank_addr: assert property (@(posedge core_clk) disable iff (rst)
		(phase_reg == acx_pkg::PH_Q1 && instr_valid && file_op &&
		 instr_word[acx_pkg::BANK_BIT]) |=>
		mem_rd_en && mem_addr == {$past(bank_select_register), $past(instr_word[7:0])})
		else $error("banked address wrong");

	chk_index_addr: assert property (@(posedge core_clk) disable iff (rst)
		(phase_reg == acx_pkg::PH_Q1 && instr_valid && file_op && ext_set_enable &&
		 !instr_word[acx_pkg::BANK_BIT] && instr_word[7:0] <= acx_pkg::INDEXED_LIMIT) |=>
		mem_addr == 12'($past(index_base) + {4'h0, $past(instr_word[7:0])}))
		else $error("indexed address wrong");

	chk_andl_flags: assert property (@(posedge core_clk) disable iff (rst)
		(phase_reg == acx_pkg::PH_Q3 && op_reg == acx_pkg::OP_ANDL) |=>
		$stable(flag_c) && $stable(half_carry_flag) && $stable(signed_overflow_flag) &&
		wreg_reg == ($past(wreg_reg) & $past(lit_reg)) && !mem_wr_en)
		else $error("literal and wrong");

	chk_andf_flags: assert property (@(posedge core_clk) disable iff (rst)
		(phase_reg == acx_pkg::PH_Q3 && op_reg == acx_pkg::OP_ANDF) |=>
		$stable(flag_c) && $stable(half_carry_flag) && $stable(signed_overflow_flag) &&
		(mem_wr_en ? mem_wr_data : wreg_reg) == ($past(wreg_reg) & $past(mem_rd_data)))
		else $error("register and wrong");

	chk_zero_neg: assert property (@(posedge core_clk) disable iff (rst)
		(phase_reg == acx_pkg::PH_Q4 && op_reg != acx_pkg::OP_NONE) |->
		flag_z == ((mem_wr_en ? mem_wr_data : wreg_reg) == 8'h00) &&
		flag_n == (mem_wr_en ? mem_wr_data[7] : wreg_reg[7]))
		else $error("zero or negative flag wrong");

endmodule // acx_exec

// [verification/acx_mem_model.sv]
`timescale 1ns/1ps
// Data memory on the far side of the execution block
module acx_mem_model (
	// Clock
	input  wire logic        core_clk,
	// Memory port
	input  wire logic [11:0] mem_addr,
	input  wire logic        mem_rd_en,
	output logic      [7:0]  mem_rd_data,
	input  wire logic        mem_wr_en,
	input  wire logic [7:0]  mem_wr_data
);
	logic [7:0] mem [4096];

	initial mem_rd_data = 8'h00;

	// Byte valid only in the cycle after a read; inverted every cycle otherwise, so stale data matches again every second cycle
	always @(posedge core_clk) begin
		if (mem_rd_en) begin
			mem_rd_data <= mem[mem_addr];
		end else begin
			mem_rd_data <= ~mem_rd_data;
		end
		if (mem_wr_en) begin
			mem[mem_addr] <= mem_wr_data;
		end
	end
endmodule // acx_mem_model

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] instr_word = 16'h0000;
	logic        instr_valid = 1'b0;
	logic [3:0]  bank_sel = 4'h0;
	logic        ext = 1'b0;
	logic [11:0] ibase = 12'h000;
	logic [11:0] mem_addr;
	logic        mem_rd_en;
	logic        mem_wr_en;
	logic [7:0]  rd_data;
	logic [7:0]  wr_data;
	logic [7:0]  wreg;
	wire  [4:0]  flags;
	logic [3:0]  quarter;
	logic        instr_done;
	logic [7:0]  ew = 8'h00;
	logic [4:0]  ef = 5'h00;
	int          error_cnt = 0;
	int          compares = 0;

	always #5 core_clk = ~core_clk;

	// Flags packed as negative, signed overflow, zero, half carry, carry
	acx_exec i_dut (.core_clk(core_clk), .rst(rst), .instr_word(instr_word),
		.instr_valid(instr_valid), .bank_select_register(bank_sel), .ext_set_enable(ext),
		.index_base(ibase), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
		.mem_rd_data(rd_data), .mem_wr_en(mem_wr_en), .mem_wr_data(wr_data),
		.wreg(wreg), .flag_n(flags[4]), .signed_overflow_flag(flags[3]),
		.flag_z(flags[2]), .half_carry_flag(flags[1]), .flag_c(flags[0]),
		.quarter(quarter), .instr_done(instr_done));

	acx_mem_model i_mem (.core_clk(core_clk), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
		.mem_rd_data(rd_data), .mem_wr_en(mem_wr_en), .mem_wr_data(wr_data));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// One instruction, Q1 to next Q1; a live and-literal is offered in Q2..Q4 to prove it ignored
	task automatic op(input logic v, input logic [15:0] w, input logic [11:0] ea,
		input logic [7:0] fv);
		logic       ad, af, al, fo;
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] r;
		ad = v && w[15:10] == 6'h08;
		af = v && w[15:10] == 6'h05;
		al = v && w[15:8] == 8'h0b;
		fo = ad || af;
		s = {1'b0, ew} + {1'b0, fv} + {8'h00, ef[0]};
		h = {1'b0, ew[3:0]} + {1'b0, fv[3:0]} + {4'h0, ef[0]};
		r = ad ? s[7:0] : (af ? ew & fv : ew & w[7:0]);
		i_mem.mem[ea] = fv;
		chk("quarter", acx_pkg::PH_Q1, quarter);
		instr_word = w;
		instr_valid = v;
		@(posedge core_clk);
		#1;
		instr_word = 16'h0b00;
		instr_valid = 1'b1;
		chk("rd_en", fo, mem_rd_en);
		if (fo) chk("addr", ea, mem_addr);
		repeat (2) @(posedge core_clk);
		#1;
		chk("wr_en", fo & w[9], mem_wr_en);
		chk("quarter q4", acx_pkg::PH_Q4, quarter);
		chk("rd_en q4", 1'b0, mem_rd_en);
		if (fo & w[9]) chk("wr_data", r, wr_data);
		@(posedge core_clk);
		#1;
		chk("done", 1'b1, instr_done);
		if (ad) ef = {r[7], ew[7] == fv[7] && r[7] != ew[7], r == 8'h00, h[4], s[8]};
		if (af || al) ef = {r[7], ef[3], r == 8'h00, ef[1:0]};
		if ((fo && !w[9]) || al) ew = r;
		chk("wreg", ew, wreg);
		chk("flags", ef, flags);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Carry chain: load, carry out with write-back, carry in, signed overflow
	task automatic t_add();
		bank_sel = 4'h2;
		op(1'b1, 16'h2134, 12'h234, 8'h4d);
		op(1'b1, 16'h2334, 12'h234, 8'hff);
		op(1'b1, 16'h2134, 12'h234, 8'h02);
		op(1'b1, 16'h2134, 12'h234, 8'h30);
		$display("test add done");
	endtask

	// Access bank split, indexed offset with wrap, bank bit overriding extended mode
	task automatic t_addr();
		bank_sel = 4'h7;
		op(1'b1, 16'h15a0, 12'h7a0, 8'hf7);
		op(1'b1, 16'h145f, 12'h05f, 8'hff);
		op(1'b1, 16'h1460, 12'hf60, 8'hff);
		ext = 1'b1;
		ibase = 12'hfc0;
		op(1'b1, 16'h145f, 12'h01f, 8'hff);
		op(1'b1, 16'h1460, 12'hf60, 8'hfe);
		op(1'b1, 16'h1500, 12'h700, 8'h0f);
		ext = 1'b0;
		$display("test addressing done");
	endtask

	// Literal and file AND, flags other than n and z kept
	task automatic t_and();
		op(1'b1, 16'h2134, 12'h734, 8'ha3);
		op(1'b1, 16'h0b5f, 12'h000, 8'h00);
		op(1'b1, 16'h1642, 12'h042, 8'hc2);
		op(1'b1, 16'h0b00, 12'h000, 8'h00);
		$display("test and done");
	endtask

	// Unknown opcode and an invalid slot leave all state alone
	task automatic t_nop();
		op(1'b1, 16'hffff, 12'h000, 8'h00);
		op(1'b0, 16'h2334, 12'h234, 8'h11);
		$display("test no-op done");
	endtask

	// Mid-run reset clears live state; the first word after release is taken
	task automatic t_reset();
		rst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		rst = 1'b0;
		ew = 8'h00;
		ef = 5'h00;
		chk("reset quarter", acx_pkg::PH_Q1, quarter);
		chk("reset wreg", 8'h00, wreg);
		chk("reset flags", 5'h00, flags);
		chk("reset done", 1'b0, instr_done);
		op(1'b1, 16'h2134, 12'h734, 8'h80);
		$display("test reset done");
	endtask

	// Hang guard well beyond the run length
	initial begin
		#100000;
		error_cnt++;
		end_of_test();
	end

	initial begin
		repeat (2) @(posedge core_clk);
		#1;
		rst = 1'b0;
		chk("reset wreg", 8'h00, wreg);
		chk("reset flags", 5'h00, flags);
		t_add();
		t_addr();
		t_and();
		t_nop();
		t_reset();
		end_of_test();
	end
endmodule // testbench
